// ---- core/pcs_consts.svh ----
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_PC_W_DEF   9
`define PCS_JADDR_W    9
`define PCS_FA_W       5
`define PCS_FA_INDIRECT_DATA_PORT    5'h00
`define PCS_FA_PCL     5'h02
`define PCS_FA_PTR     5'h04
`define PCS_PTR_PAD    3'h7
`define PCS_PTR_RST    5'h00
`define PCS_AXI_AW     8
`define PCS_OFS_PTR    8'h00
`define PCS_OFS_PCL    8'h04
`define PCS_OFS_PC     8'h08
`define PCS_RESP_OKAY  2'h0
`define PCS_RESP_SLV   2'h2
`endif

// ---- core/pcs_pkg.sv ----
package pcs_pkg;
   typedef enum logic [1:0] {
      OP_SEQ,
      OP_JUMP,
      OP_CALL,
      OP_RETURN_WITH_LITERAL
   } op_type;
   typedef enum logic {
      WR_COLLECT,
      WR_RESP
   } wr_state_type;
   typedef enum logic [1:0] {
      SRC_MEM,
      SRC_ZERO,
      SRC_LOCAL
   } rd_src_type;
endpackage : pcs_pkg

// ---- core/stack_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface stack_if #(parameter int W = 9);
   logic         push;
   logic         pop;
   logic [W-1:0] push_data;
   logic [W-1:0] top;
   modport core (output push, output pop, output push_data, input top);
   modport stk  (input push, input pop, input push_data, output top);
endinterface : stack_if
`default_nettype wire

// ---- core/return_stack.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module return_stack #(
   parameter int W = `PCS_PC_W_DEF
) (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   stack_if.stk      sp
);
   logic [W-1:0] level1;
   logic [W-1:0] level2;

   // entries are data, not control: left unreset
   always_ff @(posedge clk_i) begin
      if (sp.push) begin
         level2 <= level1;
         level1 <= sp.push_data;
      end else if (sp.pop) begin
         level1 <= level2;
      end
   end

   assign sp.top = level1;

   property p_pop_keeps;
      @(posedge clk_i) disable iff (!nrst_i)
         (sp.pop && !sp.push) |=> (level2 == $past(level2));
   endproperty
   a_pop_keeps: assert property (p_pop_keeps)
      else $error("level two changed on a pop");

   property p_two_newest;
      @(posedge clk_i) disable iff (!nrst_i)
         sp.push ##1 sp.push |=> (level2 == $past(sp.push_data, 2));
   endproperty
   a_two_newest: assert property (p_two_newest)
      else $error("older return address not kept in level two");
endmodule : return_stack
`default_nettype wire

// ---- core/pc_flow_core.sv ----
// Function
// - counter steps by one on each OP_SEQ cycle with no low-byte write
// - jump loads all nine counter bits
// - pc_low_byte maps counter bits 7..0
// - call and low-byte writes clear bit 8
// - low-byte writes act as computed jumps
// - reset sets every counter bit
// - counter wraps from last word to zero
// - two-entry stack, width follows parameter
// - call shifts level1 down, pushes pc+1
// - only two newest returns are kept
// - return loads pc from level1, shifts up
// - underflow repeats the level2 value
// - return loads literal into working register
// - no overflow or underflow flag exists
// - indirect port redirects through the pointer
// - self-addressed indirect read returns zero
// - self-addressed indirect write stores nothing
// - pointer holds five address bits
// - pointer upper three bits read ones
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pc_flow_core
   import pcs_pkg::*;
#(
   parameter int PC_W = `PCS_PC_W_DEF
) (
   input  wire logic                   CLK_I,
   input  wire logic                   NRST_I,
   input  wire pcs_pkg::op_type        OP_I,
   input  wire logic [`PCS_JADDR_W-1:0] ADDR_I,
   input  wire logic [7:0]             LIT_I,
   input  wire logic [`PCS_FA_W-1:0]   FILE_ADDR_I,
   input  wire logic                   FILE_RE_I,
   input  wire logic                   FILE_WE_I,
   input  wire logic [7:0]             FILE_WDATA_I,
   input  wire logic [7:0]             MEM_RDATA_I,
   output var  logic [PC_W-1:0]        PC_O,
   output var  logic                   W_LOAD_O,
   output var  logic [7:0]             W_DATA_O,
   output var  logic [`PCS_FA_W-1:0]   MEM_ADDR_O,
   output var  logic                   MEM_RE_O,
   output var  logic                   MEM_WE_O,
   output var  logic [7:0]             MEM_WDATA_O,
   output var  logic                   FILE_RVALID_O,
   output var  logic [7:0]             FILE_RDATA_O,
   input  wire logic [`PCS_AXI_AW-1:0] AWADDR_I,
   input  wire logic                   AWVALID_I,
   output var  logic                   AWREADY_O,
   input  wire logic [31:0]            WDATA_I,
   input  wire logic [3:0]             WSTRB_I,
   input  wire logic                   WVALID_I,
   output var  logic                   WREADY_O,
   output var  logic [1:0]             BRESP_O,
   output var  logic                   BVALID_O,
   input  wire logic                   BREADY_I,
   input  wire logic [`PCS_AXI_AW-1:0] ARADDR_I,
   input  wire logic                   ARVALID_I,
   output var  logic                   ARREADY_O,
   output var  logic [31:0]            RDATA_O,
   output var  logic [1:0]             RRESP_O,
   output var  logic                   RVALID_O,
   input  wire logic                   RREADY_I
);
   import pcs_pkg::*;

   generate
      if (PC_W != 8 && PC_W != 9) begin : g_bad_width
         $error("PC_W must be 8 or 9");
      end
   endgenerate
   // program counter and its candidate next values
   logic [PC_W-1:0]      pc_inc;
   logic [PC_W-1:0]      jump_tgt;
   logic [PC_W-1:0]      call_tgt;
   logic [PC_W-1:0]      pcl_tgt;
   logic [`PCS_FA_W-1:0] ptr;
   logic [`PCS_FA_W-1:0] eff;
   logic                 eff_self;
   logic                 eff_mem;
   logic                 pcl_wr;
   logic                 ptr_wr;
   logic                 axi_ptr_wr;
   rd_src_type           rd_src;
   logic                 rd_pend;
   logic [7:0]           rd_local;
   stack_if #(.W(PC_W)) stk_bus ();
   return_stack #(.W(PC_W)) u_stack (
      .clk_i  (CLK_I),
      .nrst_i (NRST_I),
      .sp     (stk_bus.stk)
   );

   assign pc_inc   = PC_O + 1'b1;
   assign jump_tgt = ADDR_I[PC_W-1:0];
   // zero extension leaves bit 8 clear, so calls land in the first 256
   assign call_tgt = PC_W'(LIT_I);
   assign pcl_tgt  = PC_W'(FILE_WDATA_I);
   // effective file address after indirect redirection
   assign eff      = (FILE_ADDR_I == `PCS_FA_INDIRECT_DATA_PORT) ? ptr : FILE_ADDR_I;
   assign eff_self = (eff == `PCS_FA_INDIRECT_DATA_PORT);
   assign eff_mem  = !eff_self && (eff != `PCS_FA_PCL)
                     && (eff != `PCS_FA_PTR);
   // a branch in the same cycle outranks a low-byte write
   assign pcl_wr   = FILE_WE_I && (eff == `PCS_FA_PCL)
                     && (OP_I == OP_SEQ);
   assign ptr_wr   = FILE_WE_I && (eff == `PCS_FA_PTR);
   assign stk_bus.push      = (OP_I == OP_CALL);
   assign stk_bus.push_data = pc_inc;
   assign stk_bus.pop       = (OP_I == OP_RETURN_WITH_LITERAL);
   // no overflow or underflow detection anywhere
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         PC_O <= '1;
      end else begin
         case (OP_I)
            OP_JUMP:  PC_O <= jump_tgt;
            OP_CALL:  PC_O <= call_tgt;
            OP_RETURN_WITH_LITERAL: PC_O <= stk_bus.top;
            default:  PC_O <= pcl_wr ? pcl_tgt : pc_inc;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         W_LOAD_O <= 1'b0;
         W_DATA_O <= 8'h00;
      end else begin
         W_LOAD_O <= (OP_I == OP_RETURN_WITH_LITERAL);
         if (OP_I == OP_RETURN_WITH_LITERAL) begin
            W_DATA_O <= LIT_I;
         end
      end
   end

   // pointer: the file port wins over a bus write in the same cycle
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ptr <= `PCS_PTR_RST;
      end else if (ptr_wr) begin
         ptr <= FILE_WDATA_I[`PCS_FA_W-1:0];
      end else if (axi_ptr_wr) begin
         ptr <= w_data;
      end
   end

   // data memory side, one cycle behind the file request
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         MEM_ADDR_O  <= `PCS_FA_INDIRECT_DATA_PORT;
         MEM_RE_O    <= 1'b0;
         MEM_WE_O    <= 1'b0;
         MEM_WDATA_O <= 8'h00;
      end else begin
         MEM_ADDR_O  <= eff;
         MEM_RE_O    <= FILE_RE_I && eff_mem;
         MEM_WE_O    <= FILE_WE_I && eff_mem;
         MEM_WDATA_O <= FILE_WDATA_I;
      end
   end

   // read source is fixed when the request is taken
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         rd_pend  <= 1'b0;
         rd_src   <= SRC_ZERO;
         rd_local <= 8'h00;
      end else begin
         rd_pend <= FILE_RE_I;
         if (eff_self) begin
            rd_src <= SRC_ZERO;
         end else if (eff_mem) begin
            rd_src <= SRC_MEM;
         end else begin
            rd_src <= SRC_LOCAL;
         end
         rd_local <= (eff == `PCS_FA_PCL) ? PC_O[7:0]
                     : {`PCS_PTR_PAD, ptr};
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         FILE_RVALID_O <= 1'b0;
         FILE_RDATA_O  <= 8'h00;
      end else begin
         FILE_RVALID_O <= rd_pend;
         case (rd_src)
            SRC_MEM:   FILE_RDATA_O <= MEM_RDATA_I;
            SRC_LOCAL: FILE_RDATA_O <= rd_local;
            default:   FILE_RDATA_O <= 8'h00;
         endcase
      end
   end

   // register bus slave: address and data may arrive in either order
   wr_state_type               wr_state;
   logic                       aw_full;
   logic                       w_full;
   logic [`PCS_AXI_AW-1:0]     aw_addr;
   logic [`PCS_FA_W-1:0]       w_data;
   logic                       w_lane0;
   logic                       wr_go;

   assign wr_go      = (wr_state == WR_COLLECT) && aw_full && w_full;
   assign axi_ptr_wr = wr_go && (aw_addr == `PCS_OFS_PTR) && w_lane0;
   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         aw_full   <= 1'b0;
         AWREADY_O <= 1'b1;
         aw_addr   <= `PCS_OFS_PTR;
      end else if (AWVALID_I && AWREADY_O) begin
         aw_full   <= 1'b1;
         AWREADY_O <= 1'b0;
         aw_addr   <= AWADDR_I;
      end else if (BVALID_O && BREADY_I) begin
         aw_full   <= 1'b0;
         AWREADY_O <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         w_full   <= 1'b0;
         WREADY_O <= 1'b1;
         w_data   <= '0;
         w_lane0  <= 1'b0;
      end else if (WVALID_I && WREADY_O) begin
         w_full   <= 1'b1;
         WREADY_O <= 1'b0;
         w_data   <= WDATA_I[`PCS_FA_W-1:0]; // held: bus may move on
         w_lane0  <= WSTRB_I[0];
      end else if (BVALID_O && BREADY_I) begin
         w_full   <= 1'b0;
         WREADY_O <= 1'b1;
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wr_state <= WR_COLLECT;
         BVALID_O <= 1'b0;
         BRESP_O  <= `PCS_RESP_OKAY;
      end else begin
         case (wr_state)
            WR_COLLECT: begin
               if (aw_full && w_full) begin
                  BVALID_O <= 1'b1;
                  BRESP_O  <= (aw_addr == `PCS_OFS_PTR) ?
                              `PCS_RESP_OKAY : `PCS_RESP_SLV;
                  wr_state <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (BREADY_I) begin
                  BVALID_O <= 1'b0;
                  wr_state <= WR_COLLECT;
               end
            end
            default: wr_state <= WR_COLLECT;
         endcase
      end
   end

   always_ff @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ARREADY_O <= 1'b1;
         RVALID_O  <= 1'b0;
         RDATA_O   <= 32'h0000_0000;
         RRESP_O   <= `PCS_RESP_OKAY;
      end else if (ARVALID_I && ARREADY_O) begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b1;
         RRESP_O   <= `PCS_RESP_OKAY;
         case (ARADDR_I)
            `PCS_OFS_PTR: RDATA_O <= 32'({`PCS_PTR_PAD, ptr});
            `PCS_OFS_PCL: RDATA_O <= 32'(PC_O[7:0]);
            `PCS_OFS_PC:  RDATA_O <= 32'(PC_O);
            default: begin
               RDATA_O <= 32'h0000_0000;
               RRESP_O <= `PCS_RESP_SLV;
            end
         endcase
      end else if (RVALID_O && RREADY_I) begin
         RVALID_O  <= 1'b0;
         ARREADY_O <= 1'b1;
      end
   end
   // checks
   property p_pc_step;
      @(posedge CLK_I) disable iff (!NRST_I)
         (NRST_I && OP_I == OP_SEQ && !pcl_wr) |=> (PC_O == $past(pc_inc));
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("counter did not step by one");
   property p_jump;
      @(posedge CLK_I) disable iff (!NRST_I)
         (OP_I == OP_JUMP) |=> (PC_O == $past(jump_tgt));
   endproperty
   a_jump: assert property (p_jump)
      else $error("jump target not loaded");
   property p_call_low;
      @(posedge CLK_I) disable iff (!NRST_I)
         (OP_I == OP_CALL) |=> (PC_O == PC_W'($past(LIT_I)));
   endproperty
   a_call_low: assert property (p_call_low)
      else $error("call target wrong or bit 8 not clear");
   property p_pcl_jump;
      @(posedge CLK_I) disable iff (!NRST_I)
         pcl_wr |=> (PC_O == PC_W'($past(FILE_WDATA_I)));
   endproperty
   a_pcl_jump: assert property (p_pcl_jump)
      else $error("low byte write did not jump");
   property p_wrap;
      @(posedge CLK_I) disable iff (!NRST_I)
         (NRST_I && PC_O == {PC_W{1'b1}} && OP_I == OP_SEQ && !pcl_wr)
            |=> (PC_O == '0);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("counter did not wrap to zero");
   property p_call_ret;
      @(posedge CLK_I) disable iff (!NRST_I)
         (OP_I == OP_CALL) ##1 (OP_I == OP_RETURN_WITH_LITERAL)
            |=> (PC_O == $past(pc_inc, 2));
   endproperty
   a_call_ret: assert property (p_call_ret)
      else $error("return did not reach call plus one");
   property p_ret_w;
      @(posedge CLK_I) disable iff (!NRST_I)
         (OP_I == OP_RETURN_WITH_LITERAL) |=> (W_LOAD_O && W_DATA_O == $past(LIT_I));
   endproperty
   a_ret_w: assert property (p_ret_w)
      else $error("literal not loaded on return");
   property p_self_rd;
      @(posedge CLK_I) disable iff (!NRST_I)
         (FILE_RE_I && eff_self)
            |-> ##2 (FILE_RVALID_O && FILE_RDATA_O == 8'h00);
   endproperty
   a_self_rd: assert property (p_self_rd)
      else $error("self indirect read not zero");
   property p_self_wr;
      @(posedge CLK_I) disable iff (!NRST_I)
         (FILE_WE_I && eff_self) |=> !MEM_WE_O;
   endproperty
   a_self_wr: assert property (p_self_wr)
      else $error("self indirect write reached memory");
   property p_redirect;
      @(posedge CLK_I) disable iff (!NRST_I)
         (FILE_WE_I && FILE_ADDR_I == `PCS_FA_INDIRECT_DATA_PORT && eff_mem)
            |=> (MEM_WE_O && MEM_ADDR_O == $past(ptr));
   endproperty
   a_redirect: assert property (p_redirect)
      else $error("indirect write not sent to pointer address");
   property p_ptr_pad;
      @(posedge CLK_I) disable iff (!NRST_I)
         (ARVALID_I && ARREADY_O && ARADDR_I == `PCS_OFS_PTR)
            |=> (RVALID_O && RDATA_O[7:5] == `PCS_PTR_PAD);
   endproperty
   a_ptr_pad: assert property (p_ptr_pad)
      else $error("pointer upper bits not ones");
endmodule : pc_flow_core
`default_nettype wire

// ---- verif/data_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
   input  wire logic       clk_i,
   input  wire logic [4:0] addr_i,
   input  wire logic       re_i,
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   output var  logic [7:0] rdata_o
);
   logic [7:0] mem [32];
   logic [7:0] last;
   initial begin
      for (int i = 0; i < 32; i++) begin
         mem[i] = 8'(i) ^ 8'ha5;
      end
      last = 8'h00;
   end
   always @(posedge clk_i) begin
      if (we_i) begin
         mem[addr_i] <= wdata_i;
      end
      if (re_i) begin
         last <= mem[addr_i];
      end
   end
   // no stale byte outside a read: a sloppy sampler sees garbage
   assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule : data_mem_model
`default_nettype wire

// ---- verif/pc_stack_indirect_addressing_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcs_consts.svh"
module pc_stack_indirect_addressing_tb_top;
   import pcs_pkg::*;
   logic        clk, nrst, fre, fwe, mre, mwe, frv, wl;
   op_type      op;
   logic [8:0]  jaddr, pc, pexp;
   logic [7:0]  lit, fwd, mrd, wd, mwd, frdat, plit, awaddr, araddr;
   logic [4:0]  fa, ma;
   logic        awv, awr, wv, wr, bv, br, arv, arr, rv, rr, pwl, pv;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   int          n_mismatch, num_checks, cyc;

   pc_flow_core dut_u (.CLK_I(clk), .NRST_I(nrst), .OP_I(op),
      .ADDR_I(jaddr), .LIT_I(lit), .FILE_ADDR_I(fa), .FILE_RE_I(fre),
      .FILE_WE_I(fwe), .FILE_WDATA_I(fwd), .MEM_RDATA_I(mrd), .PC_O(pc),
      .W_LOAD_O(wl), .W_DATA_O(wd), .MEM_ADDR_O(ma), .MEM_RE_O(mre),
      .MEM_WE_O(mwe), .MEM_WDATA_O(mwd), .FILE_RVALID_O(frv),
      .FILE_RDATA_O(frdat), .AWADDR_I(awaddr), .AWVALID_I(awv),
      .AWREADY_O(awr), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wv),
      .WREADY_O(wr), .BRESP_O(bresp), .BVALID_O(bv), .BREADY_I(br),
      .ARADDR_I(araddr), .ARVALID_I(arv), .ARREADY_O(arr),
      .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rr));
   data_mem_model mem_u (.clk_i(clk), .addr_i(ma), .re_i(mre),
      .we_i(mwe), .wdata_i(mwd), .rdata_o(mrd));

   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   // op driven now is taken next edge; its result is checked one call later
   task ins(input op_type o, input logic [8:0] a, input logic [7:0] l,
            input logic [8:0] e, input logic w);
      @(posedge clk);
      op <= o;
      jaddr <= a;
      lit <= l;
      #1;
      if (pv) begin
         cmp(32'(pc), 32'(pexp));
         cmp(32'(wl), 32'(pwl));
         if (pwl) begin
            cmp(32'(wd), 32'(plit));
         end
      end
      pexp = e;
      pwl = w;
      plit = l;
      pv = 1'b1;
   endtask : ins

   task fwr(input logic [4:0] a, input logic [7:0] d);
      pv = 1'b0;
      @(posedge clk);
      fa <= a;
      fwe <= 1'b1;
      fwd <= d;
      @(posedge clk);
      fwe <= 1'b0;
      #1;
   endtask : fwr

   task frd(input logic [4:0] a, input logic [7:0] e, input logic m);
      pv = 1'b0;
      @(posedge clk);
      fa <= a;
      fre <= 1'b1;
      @(posedge clk);
      fre <= 1'b0;
      #1;
      cmp(32'(mre), 32'(m));
      @(posedge clk);
      #1;
      cmp(32'(frv), 32'h1);
      cmp(32'(frdat), 32'(e));
   endtask : frd

   task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic awd, wdn;
      @(posedge clk);
      awaddr <= a;
      awv <= 1'b1;
      wdata <= d;
      wv <= 1'b1;
      br <= 1'b1;
      awd = 1'b0;
      wdn = 1'b0;
      while (!(awd && wdn)) begin
         @(posedge clk);
         if (!awd && awr) begin
            awd = 1'b1;
            awv <= 1'b0;
         end
         if (!wdn && wr) begin
            wdn = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clk); while (bv !== 1'b1);
      br <= 1'b0;
      cmp(32'(bresp), 32'(er));
   endtask : axw

   task axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rv !== 1'b1);
      rr <= 1'b0;
      cmp(rdata, e);
      cmp(32'(rresp), 32'(er));
   endtask : axr

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // run needs under a hundred cycles; the ceiling only catches a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end

   initial begin
      {nrst, fre, fwe, awv, wv, br, arv, rr, pv, pwl} = '0;
      {jaddr, lit, fa, fwd, awaddr, araddr, wdata} = '0;
      op = OP_SEQ;
      wstrb = 4'hf;
      repeat (3) @(posedge clk);
      #1;
      cmp(32'(pc), 32'h1ff);
      @(posedge clk);
      nrst <= 1'b1;
      pexp = 9'h000;
      pv = 1'b1;
      ins(OP_SEQ, 9'h000, 8'h00, 9'h001, 1'b0);
      ins(OP_JUMP, 9'h1a5, 8'h00, 9'h1a5, 1'b0);
      ins(OP_JUMP, 9'h105, 8'h00, 9'h105, 1'b0);
      ins(OP_CALL, 9'h000, 8'h40, 9'h040, 1'b0);
      ins(OP_CALL, 9'h000, 8'h50, 9'h050, 1'b0);
      ins(OP_CALL, 9'h000, 8'h60, 9'h060, 1'b0);
      ins(OP_RETURN_WITH_LITERAL, 9'h000, 8'ha1, 9'h051, 1'b1);
      ins(OP_RETURN_WITH_LITERAL, 9'h000, 8'ha2, 9'h041, 1'b1);
      ins(OP_RETURN_WITH_LITERAL, 9'h000, 8'ha3, 9'h041, 1'b1);
      ins(OP_RETURN_WITH_LITERAL, 9'h000, 8'ha4, 9'h041, 1'b1);
      ins(OP_JUMP, 9'h123, 8'h00, 9'h123, 1'b0);
      ins(OP_JUMP, 9'h123, 8'h00, 9'h123, 1'b0);
      frd(`PCS_FA_PCL, 8'h23, 1'b0);
      axr(`PCS_OFS_PC, 32'h123, `PCS_RESP_OKAY);
      axr(`PCS_OFS_PCL, 32'h23, `PCS_RESP_OKAY);
      ins(OP_JUMP, 9'h1c0, 8'h00, 9'h1c0, 1'b0);
      ins(OP_SEQ, 9'h000, 8'h00, 9'h1c1, 1'b0);
      ins(OP_SEQ, 9'h000, 8'h00, 9'h1c2, 1'b0);
      fwr(`PCS_FA_PCL, 8'h37);
      cmp(32'(pc), 32'h037);
      cmp(32'(mwe), 32'h0);
      fwr(`PCS_FA_PTR, 8'h09);
      frd(`PCS_FA_PTR, 8'he9, 1'b0);
      fwr(`PCS_FA_INDIRECT_DATA_PORT, 8'h10);
      cmp({mwe, 6'h0, ma, 12'h0, mwd}, {1'b1, 6'h0, 5'h09, 12'h0, 8'h10});
      frd(`PCS_FA_INDIRECT_DATA_PORT, 8'h10, 1'b1);
      fwr(`PCS_FA_PTR, 8'h02);
      fwr(`PCS_FA_INDIRECT_DATA_PORT, 8'h48);
      cmp(32'(pc), 32'h048);
      fwr(`PCS_FA_PTR, 8'hff);
      frd(`PCS_FA_PTR, 8'hff, 1'b0);
      fwr(`PCS_FA_PTR, 8'h00);
      frd(`PCS_FA_INDIRECT_DATA_PORT, 8'h00, 1'b0);
      fwr(`PCS_FA_INDIRECT_DATA_PORT, 8'h77);
      cmp(32'(mwe), 32'h0);
      axr(`PCS_OFS_PTR, 32'he0, `PCS_RESP_OKAY);
      axw(`PCS_OFS_PTR, 32'h2b, `PCS_RESP_OKAY);
      axr(`PCS_OFS_PTR, 32'heb, `PCS_RESP_OKAY);
      // lane 0 disabled: answered OKAY but the pointer must not move
      wstrb <= 4'he;
      axw(`PCS_OFS_PTR, 32'h15, `PCS_RESP_OKAY);
      axr(`PCS_OFS_PTR, 32'heb, `PCS_RESP_OKAY);
      wstrb <= 4'hf;
      axw(`PCS_OFS_PCL, 32'h05, `PCS_RESP_SLV);
      axr(8'h40, 32'h0, `PCS_RESP_SLV);
      finish_test();
   end
endmodule : pc_stack_indirect_addressing_tb_top
`default_nettype wire
